// File: hdl/tmr_buzzer.sv
// buzzer divider: square wave from one bit of a tick counter
// assumes tick is a one-cycle pulse; output held low while disabled
module tmr_buzzer
   import tmr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic tick,
   input wire logic [2:0] sel,
   output logic tone
);
   logic [7:0] div_q;
   logic tone_q;

   assign tone = tone_q;

   always_ff @(posedge clk) begin
      if (rst || !en) begin
         div_q <= 8'h00;
         tone_q <= 1'b0;
      end else begin
         if (tick) begin
            div_q <= div_q + 8'h01;
         end
         // bit n toggles every 2^n ticks, a period of 2^(n+1)
         tone_q <= div_q[sel];
      end
   end
endmodule

// File: hdl/tmr_pkg.sv
// constants for the down-counter, pwm and buzzer block
// assumes one 125 MHz clock that also serves as instruction clock
package tmr_pkg;
   localparam int CLK_MHZ = 125;
   // register byte offsets on the ahb-lite slave
   localparam logic [7:0] OFS_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_CTRL_B = 8'h04;
   localparam logic [7:0] OFS_RLD_LO = 8'h08;
   localparam logic [7:0] OFS_HI_BITS = 8'h0c;
   localparam logic [7:0] OFS_DUTY_A = 8'h10;
   localparam logic [7:0] OFS_DUTY_B = 8'h14;
   localparam logic [7:0] OFS_CTRL_PB = 8'h18;
   localparam logic [7:0] OFS_DUTY_C = 8'h1c;
   localparam logic [7:0] OFS_DUTY_CH = 8'h20;
   localparam logic [7:0] OFS_CTRL_PC = 8'h24;
   localparam logic [7:0] OFS_BUZ = 8'h28;
   localparam logic [7:0] OFS_PS_VAL = 8'h2c;
   localparam logic [7:0] OFS_IRQ_FLAG = 8'h30;
   localparam logic [7:0] OFS_IRQ_EN = 8'h34;
   localparam logic [7:0] OFS_GIE = 8'h38;
   localparam logic [7:0] OFS_COUNT = 8'h3c;
   // field positions
   localparam int B_EN = 0;
   localparam int B_RELOAD = 1;
   localparam int B_ONESHOT = 2;
   localparam int B_POL = 6;
   localparam int B_OEN = 7;
   localparam int B_SRC = 5;
   localparam int B_EDGE = 4;
   localparam int B_PS_N = 3;
   localparam int B_UFLAG = 3;
   localparam int B_GIE = 0;
   localparam int B_BZ_SRC = 3;
   // reset values, counter constants and the ahb-lite nonseq transfer code
   localparam logic [7:0] CTRL_B_RST = 8'h08;
   localparam logic [9:0] WRAP_VAL = 10'h3ff;
   localparam logic [9:0] CNT_RST = 10'h3ff;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // merges upper two bits and low byte into a 10-bit value
   function automatic logic [9:0] join10(input logic [1:0] hi, input logic [7:0] lo);
      return {hi, lo};
   endfunction
endpackage

// File: hdl/tmr_prescaler.sv
// prescaler: free binary counter, divided tick taken from its low bits
// assumes tick_in is a one-cycle pulse in the clock domain
module tmr_prescaler
   import tmr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tick_in,
   input wire logic clear,
   input wire logic [2:0] rate,
   output logic [7:0] count,
   output logic tick_out
);
   logic [7:0] cnt_q;
   logic [7:0] mask;

   // rate n divides by 2^(n+1)
   assign mask = 8'((9'h2 << rate) - 9'h1);
   assign tick_out = tick_in && ((cnt_q & mask) == mask);
   assign count = cnt_q;

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         cnt_q <= 8'h00;
      end else if (tick_in) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule

// File: hdl/tmr_top.sv
// 10-bit down-counter with prescaler, three pwm outputs and buzzer
// assumes ahb-lite single word transfers, pins synchronous to CLOCK
// How it works
// - counter decrements only while enable bit is set
// - source select picks external pin or instruction clock
// - edge select chooses falling or rising pin edges
// - prescaler divides 1:2 to 1:256 when its enable_n bit is 0
// - prescaler count is readable
// - one-shot mode counts down once to zero then stops
// - continuous reload mode restarts from stored initial value
// - continuous wrap mode restarts from 0x3ff
// - underflow sets flag; request needs flag, enable and global enable
// - flag stays set until software writes zero
// - pwm a enable drives pin 2 as output
// - pwm a polarity bit selects active low
// - pwm a duty zero never active, 0x3ff active 1023 clocks
// - pwm a duty high bits first, applied at next wrap
// - buzzer enable with pin config drives buzzer on pin 2
// - buzzer source is prescaler or counter underflow
// - buzzer divides its source 1:2 to 1:256
// - pwm b on pin 0 with enable and polarity
// - pwm b 10-bit duty applied at next wrap
// - pwm c on pin 1 with enable and polarity
// - pwm c duty high bits in own register, applied at wrap
// - reload value buffered, loaded at underflow outside one-shot mode, or at once if disabled
module tmr_top
   import tmr_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   input wire logic EXT_CLK_PIN,
   input wire logic BUZZER_PIN_CFG,
   output logic PIN0_OUT,
   output logic PIN0_OE,
   output logic PIN1_OUT,
   output logic PIN1_OE,
   output logic PIN2_OUT,
   output logic PIN2_OE,
   output logic IRQ_REQ
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } cnt_state_t;

   cnt_state_t st_q, st_d;
   logic [7:0] ctrl_a_q, ctrl_b_q, rld_lo_q, hi_q, duty_a_lo_q, duty_b_lo_q;
   logic [7:0] ctrl_pb_q, ctrl_pc_q, duty_c_lo_q, duty_ch_q, buz_q, ien_q;
   logic gie_q, uflag_q, pend_q;
   logic [9:0] cnt_q, cnt_d, reload_q;
   logic [9:0] act_a_q, act_b_q, act_c_q;
   logic [31:0] rdata_q;
   logic [7:0] wa_q;
   logic wr_q;
   logic ext_q1, ext_q2;
   logic pwm_a_q, pwm_b_q, pwm_c_q;

   // bus decode
   wire addr_ok = HSEL && HTRANS == HTRANS_NONSEQ && HREADY;
   wire wr_now = wr_q;
   wire [7:0] wd = HWDATA[7:0];
   wire w_ctrl_a = wr_now && wa_q == OFS_CTRL_A;
   wire w_ctrl_b = wr_now && wa_q == OFS_CTRL_B;
   wire w_rld_lo = wr_now && wa_q == OFS_RLD_LO;
   wire w_hi = wr_now && wa_q == OFS_HI_BITS;
   wire w_flag = wr_now && wa_q == OFS_IRQ_FLAG;

   // control fields
   wire en = ctrl_a_q[B_EN];
   wire one_shot = ctrl_a_q[B_ONESHOT];
   wire reload_sel = ctrl_a_q[B_RELOAD];
   wire src_sel = ctrl_b_q[B_SRC];
   wire edge_sel = ctrl_b_q[B_EDGE];
   wire ps_en_n = ctrl_b_q[B_PS_N];
   wire buz_en = buz_q[B_OEN] && BUZZER_PIN_CFG;
   wire [9:0] buf_a = join10(hi_q[1:0], duty_a_lo_q);
   wire [9:0] buf_b = join10(hi_q[3:2], duty_b_lo_q);
   wire [9:0] buf_c = join10(duty_ch_q[1:0], duty_c_lo_q);
   wire [9:0] new_reload = join10(hi_q[5:4], wd);

   // pin edge detect; pin is taken as synchronous so one stage suffices
   wire rise = ext_q1 && !ext_q2;
   wire fall = !ext_q1 && ext_q2;
   wire src_tick = src_sel ? (edge_sel ? fall : rise) : 1'b1;
   wire ps_tick;
   wire [7:0] ps_count;
   wire cnt_tick = ps_en_n ? src_tick : ps_tick;
   wire running = st_q == ST_RUN;
   // en gated here too: the state lags the enable bit by one cycle
   wire step = running && en && cnt_tick;
   wire underflow = step && cnt_q == 10'h000;
   wire ld_now = w_rld_lo && !en;

   tmr_prescaler u_ps (
      .clk(CLOCK),
      .rst(SYS_RST),
      .tick_in(src_tick),
      .clear(w_ctrl_b),
      .rate(ctrl_b_q[2:0]),
      .count(ps_count),
      .tick_out(ps_tick)
   );

   wire buz_tick = buz_q[B_BZ_SRC] ? underflow : ps_tick;
   wire tone;

   tmr_buzzer u_bz (
      .clk(CLOCK),
      .rst(SYS_RST),
      .en(buz_en),
      .tick(buz_tick),
      .sel(buz_q[2:0]),
      .tone(tone)
   );

   // next counter value and state
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         ST_IDLE: begin
            if (en) begin
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!en) begin
               st_d = ST_IDLE;
            end else if (underflow && one_shot) begin
               st_d = ST_DONE;
            end
         end
         ST_DONE: begin
            // re-arm only by clearing the enable
            if (!en) begin
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      if (ld_now) begin
         cnt_d = new_reload;
      end else if (underflow) begin
         if (one_shot) begin
            cnt_d = 10'h000;
         end else if (reload_sel || pend_q) begin
            cnt_d = reload_q;
         end else begin
            cnt_d = WRAP_VAL;
         end
      end else if (step) begin
         cnt_d = cnt_q - 10'h001;
      end
   end

   // read mux sampled in the address phase
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      unique case (HADDR[7:0])
         OFS_CTRL_A: rmux[7:0] = ctrl_a_q;
         OFS_CTRL_B: rmux[7:0] = ctrl_b_q;
         OFS_RLD_LO: rmux[7:0] = rld_lo_q;
         OFS_HI_BITS: rmux[7:0] = hi_q;
         OFS_DUTY_A: rmux[7:0] = duty_a_lo_q;
         OFS_DUTY_B: rmux[7:0] = duty_b_lo_q;
         OFS_CTRL_PB: rmux[7:0] = ctrl_pb_q;
         OFS_DUTY_C: rmux[7:0] = duty_c_lo_q;
         OFS_DUTY_CH: rmux[7:0] = duty_ch_q;
         OFS_CTRL_PC: rmux[7:0] = ctrl_pc_q;
         OFS_BUZ: rmux[7:0] = buz_q;
         OFS_PS_VAL: rmux[7:0] = ps_count;
         OFS_IRQ_FLAG: rmux[B_UFLAG] = uflag_q;
         OFS_IRQ_EN: rmux[7:0] = ien_q;
         OFS_GIE: rmux[B_GIE] = gie_q;
         OFS_COUNT: rmux[9:0] = cnt_q;
         default: rmux = 32'h0000_0000;
      endcase
   end

   // ahb-lite: zero wait states, always okay
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = rdata_q;

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_q <= addr_ok && HWRITE;
         wa_q <= HADDR[7:0];
         rdata_q <= (addr_ok && !HWRITE) ? rmux : 32'h0000_0000;
      end
   end

   // software registers
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ctrl_a_q <= 8'h00;
         ctrl_b_q <= CTRL_B_RST;
         rld_lo_q <= 8'h00;
         hi_q <= 8'h00;
         duty_a_lo_q <= 8'h00;
         duty_b_lo_q <= 8'h00;
         ctrl_pb_q <= 8'h00;
         duty_c_lo_q <= 8'h00;
         duty_ch_q <= 8'h00;
         ctrl_pc_q <= 8'h00;
         buz_q <= 8'h00;
         ien_q <= 8'h00;
         gie_q <= 1'b0;
      end else if (wr_now) begin
         if (w_ctrl_a) ctrl_a_q <= wd;
         if (w_ctrl_b) ctrl_b_q <= wd;
         if (w_rld_lo) rld_lo_q <= wd;
         if (w_hi) hi_q <= wd;
         if (wa_q == OFS_DUTY_A) duty_a_lo_q <= wd;
         if (wa_q == OFS_DUTY_B) duty_b_lo_q <= wd;
         if (wa_q == OFS_CTRL_PB) ctrl_pb_q <= wd;
         if (wa_q == OFS_DUTY_C) duty_c_lo_q <= wd;
         if (wa_q == OFS_DUTY_CH) duty_ch_q <= wd;
         if (wa_q == OFS_CTRL_PC) ctrl_pc_q <= wd;
         if (wa_q == OFS_BUZ) buz_q <= wd;
         if (wa_q == OFS_IRQ_EN) ien_q <= wd;
         if (wa_q == OFS_GIE) gie_q <= wd[B_GIE];
      end
   end

   // counter, reload buffer, active duties
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         st_q <= ST_IDLE;
         cnt_q <= CNT_RST;
         reload_q <= 10'h000;
         pend_q <= 1'b0;
         act_a_q <= 10'h000;
         act_b_q <= 10'h000;
         act_c_q <= 10'h000;
         ext_q1 <= 1'b0;
         ext_q2 <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ext_q1 <= EXT_CLK_PIN;
         ext_q2 <= ext_q1;
         if (w_rld_lo) begin
            reload_q <= new_reload;
            pend_q <= en;
         end else if (underflow) begin
            pend_q <= 1'b0;
         end
         if (underflow) begin
            act_a_q <= buf_a;
            act_b_q <= buf_b;
            act_c_q <= buf_c;
         end
      end
   end

   // underflow flag: a new underflow beats a clearing write
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         uflag_q <= 1'b0;
      end else if (underflow) begin
         uflag_q <= 1'b1;
      end else if (w_flag && !wd[B_UFLAG]) begin
         uflag_q <= 1'b0;
      end
   end

   assign IRQ_REQ = uflag_q && ien_q[B_UFLAG] && gie_q;

   // duty compare; duty must not exceed reload value, else pin stays active
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         pwm_a_q <= 1'b0;
         pwm_b_q <= 1'b0;
         pwm_c_q <= 1'b0;
      end else begin
         pwm_a_q <= (cnt_q < act_a_q) ^ ctrl_a_q[B_POL];
         pwm_b_q <= (cnt_q < act_b_q) ^ ctrl_pb_q[B_POL];
         pwm_c_q <= (cnt_q < act_c_q) ^ ctrl_pc_q[B_POL];
      end
   end

   // pins; buzzer takes pin 2 over pwm a when both are on
   assign PIN2_OE = buz_en || ctrl_a_q[B_OEN];
   assign PIN2_OUT = buz_en ? tone : (ctrl_a_q[B_OEN] && pwm_a_q);
   assign PIN0_OE = ctrl_pb_q[B_OEN];
   assign PIN0_OUT = ctrl_pb_q[B_OEN] && pwm_b_q;
   assign PIN1_OE = ctrl_pc_q[B_OEN];
   assign PIN1_OUT = ctrl_pc_q[B_OEN] && pwm_c_q;

   hold_off_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (!en && !ld_now) |=> $stable(cnt_q))
      else $error("counter moved while disabled");
   inst_src_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (running && en && !src_sel && ps_en_n && cnt_q != 10'h000)
         |=> cnt_q == $past(cnt_q) - 10'h001)
      else $error("instruction clock tick missing");
   edge_sel_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (src_sel && edge_sel && $past(EXT_CLK_PIN, 2) && !$past(EXT_CLK_PIN)) |-> src_tick)
      else $error("falling pin edge not counted");
   ps_bypass_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      ps_en_n |-> (cnt_tick == src_tick))
      else $error("prescaler not bypassed");
   ps_gate_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (!ps_en_n && !ps_tick && !ld_now) |=> $stable(cnt_q))
      else $error("counter stepped without prescaler tick");
   one_shot_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (underflow && one_shot && !ld_now) |=> (cnt_q == 10'h000 && st_q == ST_DONE))
      else $error("one-shot did not stop");
   reload_val_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (underflow && !one_shot && reload_sel && !w_rld_lo) |=> cnt_q == $past(reload_q))
      else $error("reload value not restored");
   wrap_val_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (underflow && !one_shot && !reload_sel && !pend_q && !w_rld_lo) |=> cnt_q == 10'h3ff)
      else $error("wrap did not restart at 0x3ff");
   flag_set_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      underflow |=> uflag_q)
      else $error("underflow flag not set");
   flag_hold_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (uflag_q && !w_flag) |=> uflag_q)
      else $error("flag cleared without write");
   duty_apply_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (!underflow && !w_hi) ##1 underflow |=> act_a_q == $past(buf_a))
      else $error("duty not applied at wrap");
endmodule

// File: testbench/ext_clock_source.sv
// far-side model: drives the counter's external clock pin
// assumes the pin is sampled on clk; edges are placed just after a rising edge
module ext_clock_source
(
   input wire logic clk,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin = 1'b0;
   // each level held three clocks so the synchronizer cannot miss an edge
   task automatic toggle(input int n);
      repeat (n) begin
         repeat (3) @(posedge clk);
         pin <= ~pin;
      end
      repeat (3) @(posedge clk);
   endtask
endmodule

// File: testbench/tb.sv
// self-checking bench for the down-counter, pwm and buzzer block
// assumes tmr_top on ahb-lite as sole slave, ext clock from ext_clock_source
module tb
   import tmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLOCK = 1'b0;
   logic SYS_RST = 1'b1;
   logic HSEL = 1'b0;
   logic HWRITE = 1'b0;
   logic BUZZER_PIN_CFG = 1'b0;
   logic [1:0] HTRANS = 2'h0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HADDR = 32'h0;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] HRDATA;
   logic HREADYOUT, HRESP, IRQ_REQ, EXT_CLK_PIN;
   logic PIN0_OUT, PIN0_OE, PIN1_OUT, PIN1_OE, PIN2_OUT, PIN2_OE;
   logic [31:0] v;
   logic [31:0] w;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;

   tmr_top tmr_top_inst (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .EXT_CLK_PIN(EXT_CLK_PIN),
      .BUZZER_PIN_CFG(BUZZER_PIN_CFG), .PIN0_OUT(PIN0_OUT), .PIN0_OE(PIN0_OE),
      .PIN1_OUT(PIN1_OUT), .PIN1_OE(PIN1_OE), .PIN2_OUT(PIN2_OUT), .PIN2_OE(PIN2_OE),
      .IRQ_REQ(IRQ_REQ));
   ext_clock_source ext_clock_source_inst (.clk(CLOCK), .pin(EXT_CLK_PIN));

   always #4 CLOCK = ~CLOCK;

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // generous ceiling: the whole sequence needs about 28k cycles
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         $display("wrong value at %0t: run timed out", $time);
         errors = errors + 1;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // one single word transfer; waits on hready, never on a fixed count
   task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd_v);
      HSEL <= 1'b1;
      HTRANS <= HTRANS_NONSEQ;
      HADDR <= {24'h0, a};
      HWRITE <= wr_en;
      @(posedge CLOCK);
      while (HREADYOUT !== 1'b1) @(posedge CLOCK);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      @(posedge CLOCK);
      while (HREADYOUT !== 1'b1) @(posedge CLOCK);
      rd_v = HRDATA;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      bus(1'b1, a, wd, w);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] rd_v);
      bus(1'b0, a, 32'h0, rd_v);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge CLOCK);
   endtask

   // stopped counter: reload value lands in the count at once
   task automatic load(input logic [9:0] r);
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_HI_BITS, {26'h0, r[9:8], 4'h0});
      wr(OFS_RLD_LO, {24'h0, r[7:0]});
   endtask

   function automatic logic pin_of(input int i);
      return i == 0 ? PIN2_OUT : i == 1 ? PIN0_OUT : PIN1_OUT;
   endfunction

   function automatic logic [31:0] oe_exp(input int i);
      return i == 0 ? 32'h4 : i == 1 ? 32'h1 : 32'h2;
   endfunction

   function automatic logic [31:0] hi_bits(input int i, input logic [9:0] d, input logic [9:0] r);
      return {26'h0, r[9:8], i == 1 ? d[9:8] : 2'h0, i == 0 ? d[9:8] : 2'h0};
   endfunction

   function automatic int buz_period(input logic src_cnt, input int sel, input int rate);
      return src_cnt ? 4 * (2 << sel) : (2 << rate) * (2 << sel);
   endfunction

   // active cycles over four whole frames equal four times the duty
   task automatic pwm_case(input int i, input logic pol, input logic [9:0] d,
                           input logic [9:0] r, input logic wrapm);
      int fr;
      int act;
      logic [31:0] c;
      fr = wrapm ? 1024 : int'(r) + 1;
      act = 0;
      c = {24'h0, 1'b1, pol, 6'h0};
      load(r);
      wr(OFS_HI_BITS, hi_bits(i, d, r));
      if (i == 2) wr(OFS_DUTY_CH, {30'h0, d[9:8]});
      wr(i == 0 ? OFS_DUTY_A : i == 1 ? OFS_DUTY_B : OFS_DUTY_C, {24'h0, d[7:0]});
      wr(OFS_CTRL_PB, i == 1 ? c : 32'h0);
      wr(OFS_CTRL_PC, i == 2 ? c : 32'h0);
      wr(OFS_CTRL_A, (i == 0 ? c : 32'h0) | (wrapm ? 32'h1 : 32'h3));
      tick(2 * fr);
      repeat (4 * fr) begin
         @(posedge CLOCK);
         if (pin_of(i) === ~pol) act++;
      end
      chk(act, 4 * int'(d));
      chk({29'h0, PIN2_OE, PIN1_OE, PIN0_OE}, oe_exp(i));
   endtask

   // square wave: high for exactly half of four whole periods
   task automatic buz(input logic src_cnt, input int sel, input int rate);
      int p;
      int hi;
      p = buz_period(src_cnt, sel, rate);
      hi = 0;
      load(10'h3);
      wr(OFS_CTRL_B, src_cnt ? 32'h08 : 32'(rate));
      wr(OFS_BUZ, {24'h0, 1'b1, 3'h0, src_cnt, 3'(sel)});
      wr(OFS_CTRL_A, 32'h3);
      tick(2 * p);
      repeat (4 * p) begin
         @(posedge CLOCK);
         if (PIN2_OUT === 1'b1) hi++;
      end
      chk(hi, 2 * p);
      chk(32'(PIN2_OE), 32'h1);
   endtask

   initial begin
      void'($urandom(88));
      repeat (10) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      rd(OFS_CTRL_B, v);
      chk(v, {24'h0, CTRL_B_RST});
      rd(OFS_COUNT, v);
      chk(v, {22'h0, CNT_RST});
      rd(OFS_CTRL_A, v);
      chk(v, 32'h0);
      wr(8'h40, 32'hff);
      rd(8'h40, v);
      chk(v, 32'h0);
      chk({28'h0, HRESP, PIN0_OE, PIN1_OE, PIN2_OE}, 32'h0);
      $display("reset test done");
      n = $urandom_range(40, 5);
      load(10'(n));
      rd(OFS_COUNT, v);
      chk(v, 32'(n));
      tick(20);
      rd(OFS_COUNT, v);
      chk(v, 32'(n));
      wr(OFS_CTRL_A, 32'h5);
      tick(n + 20);
      rd(OFS_COUNT, v);
      chk(v, 32'h0);
      rd(OFS_IRQ_FLAG, v);
      chk(v, 32'h8);
      wr(OFS_IRQ_EN, 32'h8);
      tick(1);
      chk(32'(IRQ_REQ), 32'h0);
      wr(OFS_GIE, 32'h1);
      tick(1);
      chk(32'(IRQ_REQ), 32'h1);
      wr(OFS_IRQ_FLAG, 32'h8);
      rd(OFS_IRQ_FLAG, v);
      chk(v, 32'h8);
      wr(OFS_IRQ_FLAG, 32'h0);
      tick(1);
      chk(32'(IRQ_REQ), 32'h0);
      $display("one-shot and flag test done");
      load(10'h3);
      wr(OFS_CTRL_A, 32'h3);
      tick(30);
      rd(OFS_COUNT, v);
      chk(32'(v <= 32'h3), 32'h1);
      load(10'h3);
      wr(OFS_CTRL_A, 32'h1);
      tick(30);
      rd(OFS_COUNT, v);
      chk(32'(v >= 32'h3e0 && v <= 32'h3ff), 32'h1);
      load(10'd200);
      wr(OFS_CTRL_B, 32'h01);
      wr(OFS_CTRL_A, 32'h1);
      tick(400);
      rd(OFS_PS_VAL, v);
      rd(OFS_PS_VAL, w);
      chk(w, {24'h0, v[7:0] + 8'h02});
      wr(OFS_CTRL_A, 32'h0);
      rd(OFS_COUNT, v);
      chk(32'(v >= 32'd95 && v <= 32'd101), 32'h1);
      $display("mode and prescaler test done");
      for (int e = 0; e < 2; e++) begin
         wr(OFS_CTRL_B, e == 0 ? 32'h28 : 32'h38);
         load(10'd100);
         wr(OFS_CTRL_A, 32'h1);
         // odd toggle count: the selected edge occurs once more than the other
         ext_clock_source_inst.toggle(7);
         wr(OFS_CTRL_A, 32'h0);
         rd(OFS_COUNT, v);
         chk(v, 32'd96);
      end
      wr(OFS_CTRL_B, 32'h08);
      $display("external clock test done");
      for (int i = 0; i < 3; i++) begin
         for (int p = 0; p < 2; p++) begin
            n = $urandom_range(30, 8);
            pwm_case(i, p[0], 10'($urandom_range(n, 1)), 10'(n), 1'b0);
         end
         pwm_case(i, 1'b0, 10'h0, 10'd12, 1'b0);
         pwm_case(i, 1'($urandom), 10'h3ff, 10'h3ff, 1'b1);
      end
      load(10'h3);
      wr(OFS_CTRL_PB, 32'h0);
      wr(OFS_CTRL_PC, 32'h0);
      $display("pwm test done");
      BUZZER_PIN_CFG <= 1'b1;
      for (int s = 0; s < 8; s++) buz(1'b0, s, s < 4 ? $urandom_range(2, 0) : 0);
      buz(1'b1, 0, 0);
      buz(1'b1, 2, 0);
      BUZZER_PIN_CFG <= 1'b0;
      tick(2);
      chk(32'(PIN2_OE), 32'h0);
      $display("buzzer test done");
      print_verdict();
   end
endmodule
